//--- spram_pkg.sv
/*
 Package for the single-port RAM with read-during-write choices.
 Assumes one system clock; both ends import it whole.
*/
package spram_pkg;
    typedef enum logic [1:0] {
        SPRAM_RDW_DONT_CARE,
        SPRAM_RDW_NEW_DATA,
        SPRAM_RDW_OLD_DATA
    } spram_rdw_t;
    typedef enum logic [1:0] {
        SPRAM_CLK_SINGLE,
        SPRAM_CLK_IN_OUT,
        SPRAM_CLK_READ_WRITE,
        SPRAM_CLK_INDEPENDENT
    } spram_clk_t;
    localparam int SPRAM_DATA_W = 8;
    localparam int SPRAM_ADDR_W = 8;
    localparam int SPRAM_LANE_W = 8;
    localparam logic SPRAM_Q_RESET = 1'b0;
endpackage

//--- spram_if.sv
/*
 Interface joining the user-logic end to the memory end.
 Assumes the testbench supplies clock and reset.
*/
`timescale 1ns/1ps
`default_nettype none
interface spram_if
    import spram_pkg::*;
#(
    parameter int DATA_W = SPRAM_DATA_W,
    parameter int ADDR_W = SPRAM_ADDR_W,
    parameter int LANES = (DATA_W + SPRAM_LANE_W - 1) / SPRAM_LANE_W
);
    logic [DATA_W-1:0] wr_data;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] lane_en;
    logic wr_en;
    logic rd_en;
    logic addr_hold;
    logic clk_en;
    logic aclr;
    logic [DATA_W-1:0] rd_data;
    modport mem (
        input wr_data, addr, lane_en, wr_en, rd_en, addr_hold, clk_en, aclr,
        output rd_data
    );
    modport user (
        output wr_data, addr, lane_en, wr_en, rd_en, addr_hold, clk_en, aclr,
        input rd_data
    );
endinterface
`default_nettype wire

//--- spram_mem.sv
/*
 Memory end: single-port RAM in the embedded nine_kbit_block style.
 Assumes one clock; the user end keeps data width and strobe use legal.
*/
`timescale 1ns/1ps
`default_nettype none
module spram_mem
    import spram_pkg::*;
#(
    parameter int DATA_W = SPRAM_DATA_W,
    parameter int ADDR_W = SPRAM_ADDR_W,
    parameter int LANES = (DATA_W + SPRAM_LANE_W - 1) / SPRAM_LANE_W,
    parameter spram_rdw_t RDW_MODE = SPRAM_RDW_NEW_DATA,
    parameter spram_clk_t CLK_MODE = SPRAM_CLK_SINGLE,
    parameter bit ADDR_ACLR = 1'b1,
    parameter bit Q_ACLR = 1'b1
) (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    spram_if.mem bus,
    output logic cfg_error_o
);
    localparam int DEPTH = 1 << ADDR_W;
    logic [DATA_W-1:0] mem_reg [DEPTH];
    logic [ADDR_W-1:0] addr_reg;
    logic [DATA_W-1:0] q_reg;
    logic [ADDR_W-1:0] addr_eff;
    logic [DATA_W-1:0] q_next;
    logic clr;

    // Only single and in/out clocking fit a single port
    assign cfg_error_o = !(CLK_MODE == SPRAM_CLK_SINGLE
                           || CLK_MODE == SPRAM_CLK_IN_OUT);
    // Dual-port pairings cannot be built from this one port
    // One clock here, so every clock mode collapses onto sys_clk_i
    assign clr = !rstn_i || bus.aclr;
    assign addr_eff = bus.addr_hold ? addr_reg : bus.addr;

    always_ff @(posedge sys_clk_i or posedge clr) begin
        if (clr) begin
            // System reset always clears; aclr only when configured
            if (ADDR_ACLR || !rstn_i) begin
                addr_reg <= '0;
            end
        end else if (bus.clk_en) begin
            addr_reg <= addr_eff;
        end
    end

    // Array itself is never cleared, as in a real block
    always_ff @(posedge sys_clk_i) begin
        if (bus.clk_en && bus.wr_en) begin
            for (int i = 0; i < LANES; i++) begin
                if (bus.lane_en[i]) begin
                    for (int b = 0; b < SPRAM_LANE_W; b++) begin
                        if (i * SPRAM_LANE_W + b < DATA_W) begin
                            mem_reg[addr_eff][i*SPRAM_LANE_W+b] <=
                                bus.wr_data[i*SPRAM_LANE_W+b];
                        end
                    end
                end
            end
        end
    end

    always_comb begin
        q_next = mem_reg[addr_eff];
        if (bus.wr_en) begin
            case (RDW_MODE)
                SPRAM_RDW_NEW_DATA: begin
                    for (int i = 0; i < LANES; i++) begin
                        for (int b = 0; b < SPRAM_LANE_W; b++) begin
                            if (bus.lane_en[i] && i * SPRAM_LANE_W + b < DATA_W) begin
                                q_next[i*SPRAM_LANE_W+b] =
                                    bus.wr_data[i*SPRAM_LANE_W+b];
                            end
                        end
                    end
                end
                SPRAM_RDW_OLD_DATA: q_next = mem_reg[addr_eff];
                // Undefined in hardware; old contents shown here
                SPRAM_RDW_DONT_CARE: q_next = mem_reg[addr_eff];
                default: q_next = mem_reg[addr_eff];
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or posedge clr) begin
        if (clr) begin
            if (Q_ACLR || !rstn_i) begin
                q_reg <= {DATA_W{SPRAM_Q_RESET}};
            end
        end else if (bus.clk_en && bus.rd_en) begin
            q_reg <= q_next;
        end
    end

    assign bus.rd_data = q_reg;
endmodule
`default_nettype wire

//--- spram_user.sv
/*
 User end: drives the memory port from a plain request port.
 Assumes requests come from logic on sys_clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module spram_user
    import spram_pkg::*;
#(
    parameter int DATA_W = SPRAM_DATA_W,
    parameter int ADDR_W = SPRAM_ADDR_W,
    parameter int LANES = (DATA_W + SPRAM_LANE_W - 1) / SPRAM_LANE_W
) (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic [DATA_W-1:0] wr_data_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [LANES-1:0] lane_en_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    input wire logic addr_hold_i,
    input wire logic clk_en_i,
    input wire logic aclr_i,
    output logic [DATA_W-1:0] rd_data_o,
    spram_if.user bus
);
    // Same width both ways by construction
    assign bus.wr_data = wr_data_i;
    assign bus.addr = addr_i;
    assign bus.lane_en = lane_en_i;
    assign bus.wr_en = wr_en_i;
    assign bus.rd_en = rd_en_i;
    assign bus.addr_hold = addr_hold_i;
    assign bus.clk_en = clk_en_i;
    assign bus.aclr = aclr_i;
    // Already registered in the memory; no extra stage
    assign rd_data_o = bus.rd_data;
endmodule
`default_nettype wire

//--- spram_properties.sv
/*
 Checker on the shared interface.
 Assumes one clock and one lane.
*/
`timescale 1ns/1ps
`default_nettype none
module spram_properties
    import spram_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic [SPRAM_DATA_W-1:0] wr_data,
    input wire logic [SPRAM_ADDR_W-1:0] addr,
    input wire logic [0:0] lane_en,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic addr_hold,
    input wire logic clk_en,
    input wire logic aclr,
    input wire logic [SPRAM_DATA_W-1:0] rd_data
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    sequence s_wr; clk_en && wr_en && !addr_hold && lane_en[0] && !aclr; endsequence
    sequence s_rd; clk_en && rd_en && !aclr && !(wr_en && lane_en[0]); endsequence
    a_width_same: assert property ($bits(wr_data) == $bits(rd_data)) else $error("width");
    a_new_flow: assert property (
        s_wr ##0 rd_en ##1 !aclr |-> rd_data == $past(wr_data)) else $error("flow");
    a_store_read: assert property (
        s_wr ##1 s_rd ##0 !addr_hold && addr == $past(addr) ##1 !aclr
        |-> rd_data == $past(wr_data, 2)) else $error("store");
    a_hold_addr: assert property (
        s_wr ##1 s_rd ##0 addr_hold ##1 !aclr |-> rd_data == $past(wr_data, 2)) else $error("hold");
    a_read_keep: assert property (
        !rd_en && !aclr ##1 !aclr |-> $stable(rd_data)) else $error("read keep");
    a_gate_keep: assert property (
        !clk_en && !aclr ##1 !aclr |-> $stable(rd_data)) else $error("gate keep");
    a_clear_zero: assert property (aclr |-> rd_data == '0) else $error("clear");
    a_reset_zero: assert property ($rose(rstn_i) |-> rd_data == '0) else $error("reset");
endmodule
`default_nettype wire

//--- tb_single_port_ram_rdw.sv
/*
 Testbench for both ends with a shadow array.
 Assumes user ports pass straight to the interface.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_fail++; \
    $display("[FAIL] %0t got %h want %h", $time, a, e); end end
module tb_single_port_ram_rdw;
    import spram_pkg::*;
    logic sys_clk_i = '0, rstn_i = '0, we = '0, re = '0, ho = '0, ce = '0, ac = '0, le = '0;
    logic err, c, f;
    logic [SPRAM_DATA_W-1:0] wd = '0, q, eq = '0, mem [256];
    logic [SPRAM_ADDR_W-1:0] ad = '0, ar = '0;
    logic [31:0] rs = 32'h000153CD;
    int n_fail = 0, total_checks = 0;
    always #2 sys_clk_i = ~sys_clk_i;
    spram_if i_spram_if ();
    spram_user i_spram_user (.sys_clk_i, .rstn_i, .wr_data_i(wd), .addr_i(ad), .lane_en_i(le),
        .wr_en_i(we), .rd_en_i(re), .addr_hold_i(ho), .clk_en_i(ce), .aclr_i(ac), .rd_data_o(q),
        .bus(i_spram_if.user));
    spram_mem i_spram_mem (.sys_clk_i, .rstn_i, .bus(i_spram_if.mem), .cfg_error_o(err));
    spram_properties i_spram_properties (.sys_clk_i, .rstn_i, .wr_data(i_spram_if.wr_data),
        .addr(i_spram_if.addr), .lane_en(i_spram_if.lane_en), .wr_en(i_spram_if.wr_en),
        .rd_en(i_spram_if.rd_en), .addr_hold(i_spram_if.addr_hold), .clk_en(i_spram_if.clk_en),
        .aclr(i_spram_if.aclr), .rd_data(i_spram_if.rd_data));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    function automatic void model();
        if (ac) {eq, ar} = '0;
        else if (ce) begin
            ar = ho ? ar : ad;
            if (we && le) mem[ar] = wd;
            if (re) eq = mem[ar];
        end
    endfunction
    task automatic stop_test();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge sys_clk_i);
        rstn_i <= 1'h1;
        for (int i = 0; i < 2400; i++) begin
            @(posedge sys_clk_i);
            model();
            rs = xs(rs);
            f = i < 256;
            c = !f && rs[27:23] == 5'h0;
            // Fill first so no read sees an unwritten word; then 16 addresses force collisions
            ad <= f ? i[7:0] : {4'h0, rs[11:8]};
            wd <= rs[7:0];
            we <= f || (!c && rs[12]);
            le <= f || rs[21];
            ce <= f || rs[20:18] != 3'h0;
            ho <= !f && rs[17:15] == 3'h0;
            re <= !f && !c && rs[14:13] != 2'h0;
            ac <= c;
            if (c) eq = '0;
            #1;
            `CHK(q, eq)
        end
        `CHK(err, 1'h0)
        stop_test();
    end
    initial begin
        #20000 n_fail++;
        stop_test();
    end
endmodule
`default_nettype wire
